// ### include/adcc_pkg.sv
package adcc_pkg;
   // byte offsets within the converter's window
   localparam logic [3:0] ADDR_RES_A_HI = 4'h0;
   localparam logic [3:0] ADDR_CTRL_STAT = 4'h8;
   localparam logic [3:0] ADDR_TRIG_CTRL = 4'h9;
   localparam logic [7:0] CSR_RESET = 8'h00;
   localparam logic [7:0] TRG_RESET = 8'h7f;
   localparam logic [6:0] TRG_RSVD_ONES = 7'h7f;
   // field positions of the control/status and trigger control registers
   localparam int DONE_BIT = 7;
   localparam int IRQEN_BIT = 6;
   localparam int RUN_BIT = 5;
   localparam int SCAN_BIT = 4;
   localparam int SPEED_BIT = 3;
   localparam int TRGEN_BIT = 7;
   // conversion lengths in states (one state is one clock)
   localparam logic [8:0] CONV_SLOW = 9'h10a; // 266
   localparam logic [8:0] CONV_FAST = 9'h086; // 134
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_CONV = 2'b10
   } adcc_state_t;
endpackage

// ### test/adcc_core_model.sv
`timescale 1ns/100ps
`default_nettype none
// analog core stand-in: each input returns its own code, so a result
// stored under the wrong register or channel shows up at once
module adcc_core_model (
   input wire logic [2:0] conv_channel_i,
   output logic [9:0] conv_value_o
);
   assign conv_value_o = {conv_channel_i, 7'h2a};
endmodule
`default_nettype wire

// ### test/test_adc_control_and_result_read.sv
`timescale 1ns/100ps
`default_nettype none
module test_adc_control_and_result_read;
   import adcc_pkg::*;
   logic clk = 0, rstn = 0, rd = 0, wr = 0, wd = 0, dma = 0, trg = 0;
   logic [3:0] adr = 0;
   logic [7:0] wdat = 0;
   logic [15:0] rdat;
   logic [9:0] val;
   logic [2:0] ch;
   logic busy, irq;
   int bad_count = 0, check_count = 0, n;
   always #4 clk = ~clk;
   adcc_top u_adcc_top (.sys_clk_i(clk), .rstn_i(rstn), .bus_addr_i(adr),
      .bus_rd_i(rd), .bus_wr_i(wr), .bus_word_i(wd), .bus_wdata_i(wdat),
      .bus_rdata_o(rdat), .dma_armed_i(dma), .timer_trig_i(trg),
      .conv_value_i(val), .conv_channel_o(ch), .conv_busy_o(busy),
      .conversion_done_irq_o(irq));
   adcc_core_model u_adcc_core_model (.conv_channel_i(ch),
      .conv_value_o(val));
   // compare and count; four-state equality so x never matches
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %0t got %h want %h", $time, g, e);
      end
   endtask
   // one-cycle read strobe; data sampled a cycle late, it stands anyway
   task automatic rdc(input logic [3:0] a, input logic w,
      input logic [15:0] e);
      @(posedge clk);
      adr <= a;
      wd <= w;
      rd <= 1;
      @(posedge clk);
      rd <= 0;
      @(posedge clk);
      #1 chk(rdat, e);
   endtask
   task automatic wrc(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      adr <= a;
      wdat <= d;
      wr <= 1;
      @(posedge clk);
      wr <= 0;
   endtask
   // bounded wait; n keeps the cycle count for timing checks
   task automatic wait_irq();
      n = 0;
      while (irq !== 1'b1 && n < 700) begin
         @(posedge clk);
         n++;
      end
   endtask
   task automatic pulse();
      @(posedge clk);
      trg <= 1;
      @(posedge clk);
      trg <= 0;
   endtask
   task automatic give_verdict();
      if (bad_count == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // watchdog, far beyond the twelve hundred or so cycles the run needs
   initial begin
      #200000;
      bad_count++;
      give_verdict();
   end
   initial begin
      repeat (12) @(posedge clk);
      rstn <= 1;
      rdc(8, 0, 16'h0000);
      rdc(9, 0, 16'h007f);
      wrc(9, 8'h00);
      rdc(9, 0, 16'h007f);
      rdc(15, 0, 16'h0000);
      pulse();
      repeat (4) @(posedge clk);
      chk(busy, 0);
      wrc(8, 8'h61);
      wait_irq();
      chk(n >= 262 && n <= 272, 1);
      chk(busy, 0);
      wrc(8, 8'h41);
      rdc(8, 0, 16'h00c1);
      wrc(8, 8'hc1);
      rdc(8, 0, 16'h00c1);
      wrc(8, 8'h41);
      rdc(8, 0, 16'h0041);
      chk(irq, 0);
      rdc(2, 0, 16'h002a);
      rdc(3, 0, 16'h0080);
      rdc(2, 1, 16'h2a80);
      wrc(8, 8'h41);
      wrc(9, 8'h80);
      rdc(9, 0, 16'h00ff);
      pulse();
      wait_irq();
      chk(n >= 262 && n <= 272, 1);
      dma <= 1;
      rdc(2, 0, 16'h002a);
      dma <= 0;
      repeat (2) @(posedge clk);
      chk(irq, 0);
      wrc(8, 8'h75);
      repeat (300) @(posedge clk);
      chk(irq, 0);
      wait_irq();
      chk(irq, 1);
      chk(busy, 1);
      rdc(0, 1, 16'h8a80);
      rdc(2, 1, 16'haa80);
      wrc(8, 8'h55);
      repeat (3) @(posedge clk);
      chk(busy, 0);
      give_verdict();
   end
endmodule
`default_nettype wire

// ### verilog/adcc_top.sv
`timescale 1ns/100ps
`default_nettype none
module adcc_top (
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic [3:0] bus_addr_i,
   input wire logic bus_rd_i,
   input wire logic bus_wr_i,
   input wire logic bus_word_i,
   input wire logic [7:0] bus_wdata_i,
   output logic [15:0] bus_rdata_o,
   input wire logic dma_armed_i,
   input wire logic timer_trig_i,
   input wire logic [9:0] conv_value_i,
   output logic [2:0] conv_channel_o,
   output logic conv_busy_o,
   output logic conversion_done_irq_o
);
   import adcc_pkg::*;

   typedef struct packed {
      adcc_state_t st;
      logic [7:0] csr;
      logic trg_en;
      logic done_seen;
      logic [1:0] cur;
      logic [8:0] cnt;
      logic [7:0] temp;
      logic [3:0][9:0] res;
      logic [15:0] rdata;
   } adcc_regs_t;

   adcc_regs_t r_q, r_d;
   logic wr_csr, rd_csr, set_done, last_ch, rd_conv;
   logic [1:0] code;
   logic [8:0] conv_len;

   assign code = r_q.csr[1:0];
   assign conv_len = r_q.csr[SPEED_BIT] ? CONV_FAST : CONV_SLOW;
   assign wr_csr = bus_wr_i && bus_addr_i == ADDR_CTRL_STAT;
   assign rd_csr = bus_rd_i && bus_addr_i == ADDR_CTRL_STAT;
   assign rd_conv = (bus_rd_i || bus_wr_i) && bus_addr_i <= ADDR_TRIG_CTRL;
   assign last_ch = r_q.cur == code;

   // next state: bus effects, sequencer and done flag
   always_comb begin
      r_d = r_q;
      set_done = 1'b0;
      // register reads; upper-byte read loads the lower-byte latch
      if (bus_rd_i) begin
         r_d.rdata = 16'h0000;
         if (bus_addr_i < ADDR_CTRL_STAT) begin
            if (!bus_addr_i[0]) begin
               r_d.rdata[7:0] = r_q.res[bus_addr_i[2:1]][9:2];
               r_d.temp = {r_q.res[bus_addr_i[2:1]][1:0], 6'h00};
               if (bus_word_i) begin
                  r_d.rdata = {r_q.res[bus_addr_i[2:1]], 6'h00};
               end
            end else begin
               r_d.rdata[7:0] = r_q.temp;
            end
         end else if (bus_addr_i == ADDR_CTRL_STAT) begin
            r_d.rdata[7:0] = r_q.csr;
            if (bus_word_i) begin
               r_d.rdata = {r_q.csr, r_q.trg_en, TRG_RSVD_ONES};
            end
         end else if (bus_addr_i == ADDR_TRIG_CTRL) begin
            r_d.rdata[7:0] = {r_q.trg_en, TRG_RSVD_ONES};
         end
      end
      if (rd_csr && r_q.csr[DONE_BIT]) begin
         r_d.done_seen = 1'b1;
      end
      // control writes; a csr write clears the done bit only after it was seen, a dma access clears it at once
      if (wr_csr) begin
         r_d.csr[6:0] = bus_wdata_i[6:0];
         if (!bus_wdata_i[DONE_BIT] && r_q.done_seen) begin
            r_d.csr[DONE_BIT] = 1'b0;
            r_d.done_seen = 1'b0;
         end
      end
      if (bus_wr_i && bus_addr_i == ADDR_TRIG_CTRL) begin
         r_d.trg_en = bus_wdata_i[TRGEN_BIT];
      end
      if (dma_armed_i && rd_conv) begin
         r_d.csr[DONE_BIT] = 1'b0;
         r_d.done_seen = 1'b0;
      end
      if (timer_trig_i && r_q.trg_en) begin
         r_d.csr[RUN_BIT] = 1'b1;
      end
      // sequencer
      unique case (r_q.st)
         ST_IDLE: begin
            if (r_q.csr[RUN_BIT]) begin
               r_d.st = ST_CONV;
               r_d.cnt = 9'h001;
               // scan restarts from the group's first input
               r_d.cur = r_q.csr[SCAN_BIT] ? 2'b00 : code;
            end
         end
         ST_CONV: begin
            if (!r_d.csr[RUN_BIT]) begin
               r_d.st = ST_IDLE;
            end else if (r_q.cnt == conv_len) begin
               r_d.res[r_q.cur] = conv_value_i;
               r_d.cnt = 9'h001;
               if (!r_q.csr[SCAN_BIT]) begin
                  set_done = 1'b1;
                  r_d.csr[RUN_BIT] = 1'b0;
                  r_d.st = ST_IDLE;
               end else if (last_ch) begin
                  set_done = 1'b1;
                  r_d.cur = 2'b00;
               end else begin
                  r_d.cur = r_q.cur + 2'b01;
               end
            end else begin
               r_d.cnt = r_q.cnt + 9'h001;
            end
         end
      endcase
      if (set_done) begin
         r_d.csr[DONE_BIT] = 1'b1;
      end
   end

   // one register for the whole state
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         r_q <= '0;
         r_q.st <= ST_IDLE;
         r_q.csr <= CSR_RESET;
         r_q.trg_en <= TRG_RESET[TRGEN_BIT];
      end else begin
         r_q <= r_d;
      end
   end

   assign bus_rdata_o = r_q.rdata;
   assign conv_channel_o = {r_q.csr[2], r_q.cur};
   assign conv_busy_o = r_q.st == ST_CONV;
   assign conversion_done_irq_o = r_q.csr[DONE_BIT] && r_q.csr[IRQEN_BIT];

   // a finished conversion with the enable set must raise the request
   property p_irq;
      @(posedge sys_clk_i) disable iff (!rstn_i)
      (set_done && r_d.csr[IRQEN_BIT]) |=> conversion_done_irq_o;
   endproperty
   a_irq: assert property (p_irq) else $error("irq mismatch");

   property p_single_end;
      @(posedge sys_clk_i) disable iff (!rstn_i)
      (r_q.st == ST_CONV && !r_q.csr[SCAN_BIT] && r_q.cnt == conv_len
       && r_d.csr[RUN_BIT]) |=> (r_q.csr[DONE_BIT] && !r_q.csr[RUN_BIT]);
   endproperty
   a_single_end: assert property (p_single_end) else $error("single end");

   property p_no_clear_unseen;
      @(posedge sys_clk_i) disable iff (!rstn_i)
      (wr_csr && !r_q.done_seen && !dma_armed_i && r_q.csr[DONE_BIT])
      |=> r_q.csr[DONE_BIT];
   endproperty
   a_no_clear_unseen: assert property (p_no_clear_unseen) else $error("cleared");

   property p_trg_rd;
      @(posedge sys_clk_i) disable iff (!rstn_i)
      (bus_rd_i && bus_addr_i == ADDR_TRIG_CTRL) |=> bus_rdata_o[6:0] == 7'h7f;
   endproperty
   a_trg_rd: assert property (p_trg_rd) else $error("reserved bits");

   // last channel of a scan pass finishing while run still stands
   sequence s_scan_last;
      r_q.st == ST_CONV && r_q.csr[SCAN_BIT] && r_q.cnt == conv_len
      && last_ch && r_d.csr[RUN_BIT];
   endsequence

   // scan keeps running after a pass, with the done flag raised
   sequence s_scan_keeps_on;
      r_q.csr[DONE_BIT] && r_q.csr[RUN_BIT] && conv_busy_o;
   endsequence

   property p_scan_done;
      @(posedge sys_clk_i) disable iff (!rstn_i)
      s_scan_last |=> s_scan_keeps_on;
   endproperty
   a_scan_done: assert property (p_scan_done) else $error("scan done");

   // an enabled trigger seen while idle starts the sequencer
   sequence s_trig_seen;
      timer_trig_i && r_q.trg_en && r_q.st == ST_IDLE;
   endsequence

   property p_trg_start;
      @(posedge sys_clk_i) disable iff (!rstn_i)
      s_trig_seen |=> r_q.csr[RUN_BIT] ##1 conv_busy_o;
   endproperty
   a_trg_start: assert property (p_trg_start) else $error("trig start");

   // a trigger with the enable low must not touch the run bit
   property p_trg_off;
      @(posedge sys_clk_i) disable iff (!rstn_i)
      (timer_trig_i && !r_q.trg_en && !r_q.csr[RUN_BIT] && !wr_csr)
      |=> !r_q.csr[RUN_BIT];
   endproperty
   a_trg_off: assert property (p_trg_off) else $error("trig off");

   // clearing run mid conversion halts the sequencer at once
   property p_run_halt;
      @(posedge sys_clk_i) disable iff (!rstn_i)
      (r_q.st == ST_CONV && !r_q.csr[RUN_BIT] && !timer_trig_i && !wr_csr)
      |=> !conv_busy_o;
   endproperty
   a_run_halt: assert property (p_run_halt) else $error("run halt");

   // writing 1 to the flag leaves it set unless dma is armed
   property p_wr1_keep;
      @(posedge sys_clk_i) disable iff (!rstn_i)
      (wr_csr && bus_wdata_i[DONE_BIT] && r_q.csr[DONE_BIT] && !dma_armed_i)
      |=> r_q.csr[DONE_BIT];
   endproperty
   a_wr1_keep: assert property (p_wr1_keep) else $error("write one");

   // dma access clears the flag unless a new completion lands
   property p_dma_clr;
      @(posedge sys_clk_i) disable iff (!rstn_i)
      (dma_armed_i && rd_conv && !set_done) |=> !r_q.csr[DONE_BIT];
   endproperty
   a_dma_clr: assert property (p_dma_clr) else $error("dma clear");

   // completion beats any clear in the same cycle
   property p_set_wins;
      @(posedge sys_clk_i) disable iff (!rstn_i)
      set_done |=> r_q.csr[DONE_BIT];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("set lost");

   // reserved low bits of a result read as zero, upper byte unused
   property p_lo_zero;
      @(posedge sys_clk_i) disable iff (!rstn_i)
      (bus_rd_i && bus_addr_i < ADDR_CTRL_STAT && bus_addr_i[0])
      |=> bus_rdata_o[5:0] == 6'h00 && bus_rdata_o[15:8] == 8'h00;
   endproperty
   a_lo_zero: assert property (p_lo_zero) else $error("low bits");
endmodule
`default_nettype wire
